// >>> cpu_core_cfg.svh
// Constants for the CPU core: data map, stack, flags and timing
`ifndef CPU_CORE_CFG_SVH
`define CPU_CORE_CFG_SVH
`define IO_DIRECT_END 16'h003F
`define IO_END 16'h0FFF
`define EE_BASE 16'h1000
`define EE_END 16'h1FFF
`define SRAM_BASE 16'h2000
`define SRAM_SIZE 16'h1000
`define SRAM_TOP (`SRAM_BASE + `SRAM_SIZE - 16'h0001)
`define PMEM_KBYTES 128
`define RET_BYTES ((`PMEM_KBYTES > 128) ? 3 : 2)
`define RESET_PC 16'h0000
`define BOOT_START 16'h8000
`define SPL_ADDR 16'h003D
`define SPH_ADDR 16'h003E
`define FLAGS_ADDR 16'h003F
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_I 7
`define LOCK_INSTR 3'h4
`define MUL_CYCLES 2
`define REG_IO 3'h1
`define REG_EE 3'h2
`define REG_SRAM 3'h4
`define PTR_X 5'h1A
`define PTR_Y 5'h1C
`define PTR_Z 5'h1E
`endif

// >>> cpu_core_pkg.sv
// Types for the CPU core
`default_nettype none
package cpu_core_pkg;
  typedef enum logic [4:0] {
    S_EXEC = 5'h01,
    S_LOAD = 5'h02,
    S_MUL = 5'h04,
    S_PUSH = 5'h08,
    S_POP = 5'h10
  } phase_t;
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR = 3'h3,
    ALU_EOR = 3'h4
  } alu_op_t;
  typedef struct packed {
    logic [31:0][7:0] rf;
    logic [15:0] pc;
    logic [15:0] ir;
    logic irv;
    phase_t phase;
    logic [7:0] status_flags;
    logic [15:0] stack_pointer;
    logic [2:0] lock;
    logic [1:0] cnt;
    logic [23:0] tmp;
    logic [4:0] dst;
    logic [2:0] mkind;
    logic [15:0] dm_addr;
    logic [7:0] dm_wdata;
    logic dm_we;
    logic dm_re;
    logic [2:0] region;
    logic irq_ack;
    logic spm_strobe;
    logic [15:0] spm_addr;
    logic [15:0] spm_data;
  } core_t;
endpackage
`default_nettype wire

// >>> cpu_core_stack_and_memory_map.sv
// CPU core: prefetch, register file, ALU, multiplier, stack, data map
`include "cpu_core_cfg.svh"
`default_nettype none
// Functional notes
// - Next instruction is fetched while current one executes.
// - Thirty-two byte registers; three pairs serve as 16-bit pointers.
// - Low 4KB is I/O; 0x00-0x3F direct, rest load/store only.
// - Data 0x1000-0x1FFF is the mapped nonvolatile data window.
// - SRAM starts at 0x2000; no instruction fetch from SRAM.
// - Register and immediate ALU operations finish in one cycle.
// - Byte multiply to 16 bits, signed/unsigned/mixed, integer/fraction.
// - Every multiplication takes exactly two cycles.
// - Fetch starts at address zero; counter holds next fetch address.
// - Mostly one-word instructions, a few two-word instructions.
// - Status flags follow each arithmetic or logic result.
// - Status flags are not saved or restored around interrupts.
// - Stack pointer is two I/O bytes, reset to top of SRAM.
// - Stack grows down; push decrements, pop increments by one.
// - Call and interrupt push two or three return bytes.
// - Both return forms pop the return address into the counter.
// - Low stack byte write blocks interrupts four instructions or I/O write.
// - Flash self-write acts only from the boot section.
module cpu_core_stack_and_memory_map (
  input wire logic ref_clk,
  input wire logic arst_n,
  output logic [15:0] pm_addr,
  input wire logic [15:0] pm_data,
  output logic [15:0] dm_addr,
  output logic [7:0] dm_wdata,
  output logic dm_we,
  output logic dm_re,
  output logic [2:0] dm_region,
  input wire logic [7:0] dm_rdata,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  output logic irq_ack,
  output logic spm_strobe,
  output logic [15:0] spm_addr,
  output logic [15:0] spm_data
);
  localparam int RB = `RET_BYTES;
  cpu_core_pkg::core_t st_ff;
  cpu_core_pkg::core_t nxt_st;
  logic [4:0] d, rr, dh, alu_d;
  logic [7:0] kimm, alu_a, alu_b;
  logic [15:0] acc_addr, ptr, target, ret_addr, prod, alu_out;
  logic take_irq, is_mul, is_push, is_pop, is_call, is_ret;
  logic wr_en, rd_en, do_alu, alu_wb, spl_wr, in_boot;
  logic [8:0] pa, pb;
  logic signed [17:0] prod_s;
  cpu_core_pkg::alu_op_t alu_op;

  function automatic logic [2:0] region_of(input logic [15:0] a);
    if (a <= `IO_END) return `REG_IO;
    if (a <= `EE_END) return `REG_EE;
    if (a <= `SRAM_TOP) return `REG_SRAM;
    return 3'h0;
  endfunction

  function automatic logic [15:0] alu(input cpu_core_pkg::alu_op_t op,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
    logic [8:0] s9;
    logic [7:0] fo;
    logic v;
    fo = f;
    v = 1'b0;
    case (op)
      cpu_core_pkg::ALU_ADD: begin
        s9 = {1'b0, a} + {1'b0, b};
        v = (a[7] == b[7]) && (s9[7] != a[7]);
      end
      cpu_core_pkg::ALU_SUB: begin
        s9 = {1'b0, a} - {1'b0, b};
        v = (a[7] != b[7]) && (s9[7] != a[7]);
      end
      cpu_core_pkg::ALU_AND: s9 = {f[`FLG_C], a & b};
      cpu_core_pkg::ALU_OR: s9 = {f[`FLG_C], a | b};
      default: s9 = {f[`FLG_C], a ^ b};
    endcase
    fo[`FLG_C] = s9[8];
    fo[`FLG_Z] = (s9[7:0] == 8'h00);
    fo[`FLG_N] = s9[7];
    fo[`FLG_V] = v;
    fo[`FLG_S] = s9[7] ^ v;
    return {fo, s9[7:0]};
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.dm_we = 1'b0;
    nxt_st.dm_re = 1'b0;
    nxt_st.irq_ack = 1'b0;
    nxt_st.spm_strobe = 1'b0;
    d = st_ff.ir[8:4];
    rr = {st_ff.ir[9], st_ff.ir[3:0]};
    dh = {1'b1, st_ff.ir[7:4]};
    kimm = {st_ff.ir[11:8], st_ff.ir[3:0]};
    ptr = 16'h0000;
    acc_addr = 16'h0000;
    target = 16'h0000;
    ret_addr = 16'h0000;
    {is_mul, is_push, is_pop, is_call, is_ret} = 5'h00;
    {wr_en, rd_en, do_alu, spl_wr} = 4'h0;
    alu_wb = 1'b1;
    alu_op = cpu_core_pkg::ALU_ADD;
    alu_a = st_ff.rf[d];
    alu_b = st_ff.rf[rr];
    alu_d = d;
    alu_out = 16'h0000;
    pa = 9'h000;
    pb = 9'h000;
    prod_s = 18'sh00000;
    prod = 16'h0000;
    in_boot = (st_ff.pc - 16'h0001) >= `BOOT_START;
    take_irq = (st_ff.phase == cpu_core_pkg::S_EXEC) && st_ff.irv &&
      irq_req && st_ff.status_flags[`FLG_I] && (st_ff.lock == 3'h0);
    case (st_ff.phase)
      cpu_core_pkg::S_EXEC: begin
        // Prefetch: program memory is the only fetch source
        nxt_st.ir = pm_data;
        nxt_st.pc = st_ff.pc + 16'h0001;
        nxt_st.irv = 1'b1;
        if (take_irq) begin
          // Flags left alone; the handler saves them if needed
          nxt_st.irq_ack = 1'b1;
          is_call = 1'b1;
          ret_addr = st_ff.pc - 16'h0001;
          target = irq_vector;
        end else if (st_ff.irv) begin
          if (st_ff.lock != 3'h0) begin
            nxt_st.lock = st_ff.lock - 3'h1;
          end
          casez (st_ff.ir)
            16'b0000_11??_????_????: do_alu = 1'b1;
            16'b0001_10??_????_????: begin
              do_alu = 1'b1;
              alu_op = cpu_core_pkg::ALU_SUB;
            end
            16'b0001_01??_????_????: begin
              do_alu = 1'b1;
              alu_wb = 1'b0;
              alu_op = cpu_core_pkg::ALU_SUB;
            end
            16'b0010_00??_????_????: begin
              do_alu = 1'b1;
              alu_op = cpu_core_pkg::ALU_AND;
            end
            16'b0010_01??_????_????: begin
              do_alu = 1'b1;
              alu_op = cpu_core_pkg::ALU_EOR;
            end
            16'b0010_10??_????_????: begin
              do_alu = 1'b1;
              alu_op = cpu_core_pkg::ALU_OR;
            end
            16'b0010_11??_????_????: nxt_st.rf[d] = st_ff.rf[rr];
            16'b0011_????_????_????, 16'b0101_????_????_????,
            16'b0110_????_????_????, 16'b0111_????_????_????: begin
              do_alu = 1'b1;
              alu_a = st_ff.rf[dh];
              alu_b = kimm;
              alu_d = dh;
              alu_wb = st_ff.ir[14];
              // Bit 14 splits compare-immediate from and-immediate
              case (st_ff.ir[14:12])
                3'h6: alu_op = cpu_core_pkg::ALU_OR;
                3'h7: alu_op = cpu_core_pkg::ALU_AND;
                default: alu_op = cpu_core_pkg::ALU_SUB;
              endcase
            end
            16'b1110_????_????_????: nxt_st.rf[dh] = kimm;
            16'b1001_11??_????_????: begin
              is_mul = 1'b1;
              nxt_st.tmp[15:0] = {st_ff.rf[rr], st_ff.rf[d]};
              nxt_st.mkind = 3'h0;
            end
            16'b0000_0010_????_????: begin
              is_mul = 1'b1;
              nxt_st.tmp[15:0] = {st_ff.rf[{1'b1, st_ff.ir[3:0]}],
                st_ff.rf[dh]};
              nxt_st.mkind = 3'h3;
            end
            16'b0000_0011_????_????: begin
              is_mul = 1'b1;
              nxt_st.tmp[15:0] = {st_ff.rf[{2'h2, st_ff.ir[2:0]}],
                st_ff.rf[{2'h2, st_ff.ir[6:4]}]};
              nxt_st.mkind = {st_ff.ir[7] | st_ff.ir[3],
                st_ff.ir[7] & ~st_ff.ir[3], st_ff.ir[7] | ~st_ff.ir[3]};
            end
            16'b1001_000?_????_0000, 16'b1001_001?_????_0000: begin
              // Second word is already on the fetch bus
              acc_addr = pm_data;
              nxt_st.irv = 1'b0;
              rd_en = ~st_ff.ir[9];
              wr_en = st_ff.ir[9];
            end
            16'b1001_00??_????_1100, 16'b1000_00??_????_?000: begin
              if (st_ff.ir[12]) begin
                ptr = {st_ff.rf[`PTR_X + 5'h01], st_ff.rf[`PTR_X]};
              end else if (st_ff.ir[3]) begin
                ptr = {st_ff.rf[`PTR_Y + 5'h01], st_ff.rf[`PTR_Y]};
              end else begin
                ptr = {st_ff.rf[`PTR_Z + 5'h01], st_ff.rf[`PTR_Z]};
              end
              acc_addr = ptr;
              rd_en = ~st_ff.ir[9];
              wr_en = st_ff.ir[9];
            end
            16'b1001_001?_????_1111: begin
              is_push = 1'b1;
              wr_en = 1'b1;
              acc_addr = st_ff.stack_pointer;
              nxt_st.stack_pointer = st_ff.stack_pointer - 16'h0001;
            end
            16'b1001_000?_????_1111: begin
              is_pop = 1'b1;
              rd_en = 1'b1;
              acc_addr = st_ff.stack_pointer + 16'h0001;
              nxt_st.stack_pointer = acc_addr;
            end
            16'b1011_????_????_????: begin
              acc_addr = {10'h000, st_ff.ir[10:9], st_ff.ir[3:0]};
              rd_en = ~st_ff.ir[11];
              wr_en = st_ff.ir[11];
            end
            16'b1001_0101_000?_1000: begin
              is_ret = 1'b1;
              nxt_st.dm_re = 1'b1;
              nxt_st.dm_addr = st_ff.stack_pointer + 16'h0001;
              nxt_st.region = region_of(nxt_st.dm_addr);
              nxt_st.stack_pointer = nxt_st.dm_addr;
              nxt_st.cnt = 2'(RB - 1);
              nxt_st.tmp = 24'h000000;
              nxt_st.phase = cpu_core_pkg::S_POP;
            end
            16'b1001_0101_1110_1000: begin
              nxt_st.spm_strobe = in_boot;
              nxt_st.spm_addr = {st_ff.rf[`PTR_Z + 5'h01], st_ff.rf[`PTR_Z]};
              nxt_st.spm_data = {st_ff.rf[1], st_ff.rf[0]};
            end
            16'b1001_0100_????_1000: begin
              nxt_st.status_flags[st_ff.ir[6:4]] = ~st_ff.ir[7];
            end
            16'b1001_010?_????_111?: begin
              is_call = 1'b1;
              ret_addr = st_ff.pc + 16'h0001;
              target = pm_data;
            end
            16'b1101_????_????_????: begin
              is_call = 1'b1;
              ret_addr = st_ff.pc;
              target = st_ff.pc + {{4{st_ff.ir[11]}}, st_ff.ir[11:0]};
            end
            16'b1100_????_????_????: begin
              nxt_st.pc = st_ff.pc + {{4{st_ff.ir[11]}}, st_ff.ir[11:0]};
              nxt_st.irv = 1'b0;
            end
            16'b1111_0???_????_????: begin
              if (st_ff.status_flags[st_ff.ir[2:0]] ^ st_ff.ir[10]) begin
                nxt_st.pc = st_ff.pc + {{9{st_ff.ir[9]}}, st_ff.ir[9:3]};
                nxt_st.irv = 1'b0;
              end
            end
            default: ;
          endcase
        end
        if (do_alu) begin
          alu_out = alu(alu_op, alu_a, alu_b, st_ff.status_flags);
          nxt_st.status_flags = alu_out[15:8];
          if (alu_wb) begin
            nxt_st.rf[alu_d] = alu_out[7:0];
          end
        end
        if (is_mul) begin
          nxt_st.phase = cpu_core_pkg::S_MUL;
        end
        if (is_call) begin
          // Low byte first, so the high byte pops first
          nxt_st.dm_we = 1'b1;
          nxt_st.dm_addr = st_ff.stack_pointer;
          nxt_st.dm_wdata = ret_addr[7:0];
          nxt_st.region = region_of(st_ff.stack_pointer);
          nxt_st.tmp = {16'h0000, ret_addr[15:8]};
          nxt_st.stack_pointer = st_ff.stack_pointer - 16'h0001;
          nxt_st.cnt = 2'(RB - 1);
          nxt_st.pc = target;
          nxt_st.irv = 1'b0;
          nxt_st.phase = cpu_core_pkg::S_PUSH;
        end
        if (wr_en) begin
          if (acc_addr <= `IO_END) begin
            nxt_st.lock = 3'h0;
          end
          case (acc_addr)
            `SPL_ADDR: begin
              spl_wr = 1'b1;
              nxt_st.stack_pointer[7:0] = st_ff.rf[d];
              nxt_st.lock = `LOCK_INSTR;
            end
            `SPH_ADDR: nxt_st.stack_pointer[15:8] = st_ff.rf[d];
            `FLAGS_ADDR: nxt_st.status_flags = st_ff.rf[d];
            default: begin
              nxt_st.dm_we = 1'b1;
              nxt_st.dm_addr = acc_addr;
              nxt_st.dm_wdata = st_ff.rf[d];
              nxt_st.region = region_of(acc_addr);
            end
          endcase
        end
        if (rd_en) begin
          case (acc_addr)
            `SPL_ADDR: nxt_st.rf[d] = st_ff.stack_pointer[7:0];
            `SPH_ADDR: nxt_st.rf[d] = st_ff.stack_pointer[15:8];
            `FLAGS_ADDR: nxt_st.rf[d] = st_ff.status_flags;
            default: begin
              nxt_st.dm_re = 1'b1;
              nxt_st.dm_addr = acc_addr;
              nxt_st.region = region_of(acc_addr);
              nxt_st.dst = d;
              nxt_st.phase = cpu_core_pkg::S_LOAD;
            end
          endcase
        end
      end
      cpu_core_pkg::S_LOAD: begin
        nxt_st.rf[st_ff.dst] = dm_rdata;
        nxt_st.phase = cpu_core_pkg::S_EXEC;
      end
      cpu_core_pkg::S_MUL: begin
        pa = {st_ff.mkind[0] & st_ff.tmp[7], st_ff.tmp[7:0]};
        pb = {st_ff.mkind[1] & st_ff.tmp[15], st_ff.tmp[15:8]};
        prod_s = $signed(pa) * $signed(pb);
        prod = st_ff.mkind[2] ? {prod_s[14:0], 1'b0} : prod_s[15:0];
        {nxt_st.rf[1], nxt_st.rf[0]} = prod;
        nxt_st.status_flags[`FLG_C] = prod_s[15];
        nxt_st.status_flags[`FLG_Z] = (prod == 16'h0000);
        nxt_st.phase = cpu_core_pkg::S_EXEC;
      end
      cpu_core_pkg::S_PUSH: begin
        nxt_st.dm_we = 1'b1;
        nxt_st.dm_addr = st_ff.stack_pointer;
        nxt_st.dm_wdata = st_ff.tmp[7:0];
        nxt_st.region = region_of(st_ff.stack_pointer);
        nxt_st.tmp = {8'h00, st_ff.tmp[23:8]};
        nxt_st.stack_pointer = st_ff.stack_pointer - 16'h0001;
        nxt_st.cnt = st_ff.cnt - 2'h1;
        if (st_ff.cnt == 2'h1) begin
          nxt_st.phase = cpu_core_pkg::S_EXEC;
        end
      end
      cpu_core_pkg::S_POP: begin
        nxt_st.tmp = {st_ff.tmp[15:0], dm_rdata};
        if (st_ff.cnt == 2'h0) begin
          nxt_st.pc = {st_ff.tmp[7:0], dm_rdata};
          nxt_st.irv = 1'b0;
          nxt_st.phase = cpu_core_pkg::S_EXEC;
        end else begin
          nxt_st.dm_re = 1'b1;
          nxt_st.dm_addr = st_ff.stack_pointer + 16'h0001;
          nxt_st.region = region_of(nxt_st.dm_addr);
          nxt_st.stack_pointer = nxt_st.dm_addr;
          nxt_st.cnt = st_ff.cnt - 2'h1;
        end
      end
      default: nxt_st.phase = cpu_core_pkg::S_EXEC;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
      st_ff.pc <= `RESET_PC;
      st_ff.phase <= cpu_core_pkg::S_EXEC;
      st_ff.stack_pointer <= `SRAM_TOP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pm_addr = st_ff.pc;
  assign dm_addr = st_ff.dm_addr;
  assign dm_wdata = st_ff.dm_wdata;
  assign dm_we = st_ff.dm_we;
  assign dm_re = st_ff.dm_re;
  assign dm_region = st_ff.region;
  assign irq_ack = st_ff.irq_ack;
  assign spm_strobe = st_ff.spm_strobe;
  assign spm_addr = st_ff.spm_addr;
  assign spm_data = st_ff.spm_data;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  reset_pc_a: assert property ($rose(arst_n) |-> pm_addr == `RESET_PC)
    else $error("fetch did not start at zero");
  prefetch_a: assert property (do_alu |=> pm_addr == $past(pm_addr) + 16'h1
    && st_ff.ir == $past(pm_data))
    else $error("prefetch did not advance");
  alu_wb_a: assert property (do_alu && alu_wb |=>
    st_ff.rf[$past(alu_d)] == $past(alu_out[7:0]))
    else $error("alu result not written");
  alu_flags_a: assert property (do_alu |=>
    st_ff.status_flags == $past(alu_out[15:8]))
    else $error("flags not updated");
  mul_two_a: assert property (is_mul |=>
    st_ff.phase == cpu_core_pkg::S_MUL ##1
    st_ff.phase == cpu_core_pkg::S_EXEC)
    else $error("multiply not two cycles");
  push_dec_a: assert property (is_push |=>
    st_ff.stack_pointer == $past(st_ff.stack_pointer) - 16'h1)
    else $error("push did not decrement");
  pop_inc_a: assert property (is_pop |=>
    st_ff.stack_pointer == $past(st_ff.stack_pointer) + 16'h1)
    else $error("pop did not increment");
  call_sp_a: assert property (is_call |-> ##RB st_ff.stack_pointer ==
    $past(st_ff.stack_pointer, RB) - 16'(RB))
    else $error("call push count wrong");
  ret_sp_a: assert property (is_ret |-> ##RB st_ff.stack_pointer ==
    $past(st_ff.stack_pointer, RB) + 16'(RB))
    else $error("return pop count wrong");
  lock_set_a: assert property (spl_wr |=> st_ff.lock == `LOCK_INSTR)
    else $error("lockout not armed");
  lock_hold_a: assert property (st_ff.lock != 3'h0 |=> !irq_ack)
    else $error("interrupt taken while locked");
  irq_flags_a: assert property (take_irq |=>
    st_ff.status_flags == $past(st_ff.status_flags))
    else $error("flags touched on interrupt entry");
  io_region_a: assert property ((dm_we || dm_re) && dm_addr <= `IO_END
    |-> dm_region == `REG_IO)
    else $error("io access decoded wrong");
  ee_region_a: assert property ((dm_we || dm_re) && dm_addr >= `EE_BASE
    && dm_addr <= `EE_END |-> dm_region == `REG_EE)
    else $error("eeprom window decoded wrong");
  spm_boot_a: assert property (spm_strobe |->
    $past(st_ff.pc) > `BOOT_START)
    else $error("self-write outside boot");
  mul_c: cover property (is_mul ##2 do_alu);
  irq_c: cover property (take_irq ##[1:8] is_ret);
  lock_c: cover property (spl_wr ##1 irq_req && st_ff.lock != 3'h0);
endmodule
`default_nettype wire

// >>> program_data_memory.sv
// Far-side model: async program ROM and byte-wide data memory
`default_nettype none
module program_data_memory (
  input wire logic ref_clk,
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_data,
  input wire logic [15:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we,
  input wire logic dm_re,
  output logic [7:0] dm_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] prog [0:65535];
  logic [7:0] data [0:65535];
  logic [7:0] junk_ff = 8'hA5;
  // Combinational fetch so the core can prefetch every cycle
  assign pm_data = prog[pm_addr];
  // Unselected read bus toggles so a stale value never looks valid
  assign dm_rdata = dm_re ? data[dm_addr] : junk_ff;
  always @(posedge ref_clk) begin
    junk_ff <= ~junk_ff;
    if (dm_we) begin
      data[dm_addr] <= dm_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> cpu_core_stack_and_memory_map_tb.sv
// Self-checking bench for the CPU core
`default_nettype none
module cpu_core_stack_and_memory_map_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, arst_n, irq_req, dm_we, dm_re, irq_ack, spm_strobe;
  logic [15:0] irq_vector, pm_addr, pm_data, dm_addr, spm_addr, spm_data;
  logic [7:0] dm_wdata, dm_rdata;
  logic [2:0] dm_region;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int acks, ack_idx, spm_n;
  logic [15:0] wa [$];
  logic [7:0] wd [$];
  logic [2:0] wr [$];
  logic [15:0] spm_a, spm_d;

  cpu_core_stack_and_memory_map cpu_core_stack_and_memory_map_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .pm_addr(pm_addr),
    .pm_data(pm_data), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .dm_re(dm_re), .dm_region(dm_region),
    .dm_rdata(dm_rdata), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack(irq_ack), .spm_strobe(spm_strobe), .spm_addr(spm_addr),
    .spm_data(spm_data));
  program_data_memory program_data_memory_inst (
    .ref_clk(ref_clk), .pm_addr(pm_addr), .pm_data(pm_data),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
    .dm_re(dm_re), .dm_rdata(dm_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    arst_n = 1'b0;
    irq_req = 1'b0;
    irq_vector = 16'h0000;
  end

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("ERROR %0t run hung", $time);
      conclude();
    end
  end

  // Bus monitor; interrupt request dropped once answered
  always @(posedge ref_clk) begin
    if (arst_n && irq_ack) begin
      acks++;
      ack_idx = wa.size();
      irq_req <= 1'b0;
    end
    if (arst_n && dm_we) begin
      wa.push_back(dm_addr);
      wd.push_back(dm_wdata);
      wr.push_back(dm_region);
    end
    if (arst_n && spm_strobe) begin
      spm_n++;
      spm_a = spm_addr;
      spm_d = spm_data;
    end
  end

  task automatic conclude();
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic exp_wr(input int i, input logic [15:0] a,
                        input logic [7:0] d, input logic [2:0] r);
    chk(16'(wa.size() > i), 16'h0001, "write count");
    if (wa.size() > i) begin
      chk(wa[i], a, "write addr");
      chk({8'h00, wd[i]}, {8'h00, d}, "write data");
      chk({13'h0000, wr[i]}, {13'h0000, r}, "write region");
    end
  endtask

  // Clears program and logs under reset; logs wait one reset edge so
  // the monitor cannot append a write left from the last scenario
  task automatic prep();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    for (int i = 0; i < 65536; i++) begin
      program_data_memory_inst.prog[i] = 16'h0000;
    end
    @(posedge ref_clk);
    wa.delete();
    wd.delete();
    wr.delete();
    acks = 0;
    ack_idx = -1;
    spm_n = 0;
  endtask

  task automatic go(input int n);
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic put(input int a, input logic [15:0] w);
    program_data_memory_inst.prog[a] = w;
  endtask

  task automatic t_alu_map();
    logic [15:0] p [16];
    p = '{16'hE005, 16'hE013, 16'h0F01, 16'h9300, 16'h2000, 16'h9300,
          16'h1000, 16'h9300, 16'h0040, 16'hEF2F, 16'hEF3E, 16'h9F23,
          16'h920F, 16'h921F, 16'h9300, 16'h3000};
    prep();
    for (int i = 0; i < 16; i++) put(i, p[i]);
    go(0);
    chk(pm_addr, 16'h0000, "pc in reset");
    @(posedge ref_clk);
    #1;
    chk(pm_addr, 16'h0001, "first fetch");
    repeat (40) @(posedge ref_clk);
    exp_wr(0, 16'h2000, 8'h08, 3'h4);
    exp_wr(1, 16'h1000, 8'h08, 3'h2);
    exp_wr(2, 16'h0040, 8'h08, 3'h1);
    exp_wr(3, 16'h2FFF, 8'h02, 3'h4);
    exp_wr(4, 16'h2FFE, 8'hFD, 3'h4);
    exp_wr(5, 16'h3000, 8'h08, 3'h0);
  endtask

  // Pointer store/load, compare-equal skips a push, in, push/pop
  task automatic t_ptr_flags();
    logic [15:0] p [16];
    p = '{16'hE0A0, 16'hE2B1, 16'hE50A, 16'h930C, 16'h911C, 16'h351A,
          16'hF009, 16'h930F, 16'h5110, 16'hB72D, 16'h9310, 16'h2102,
          16'h932F, 16'h913F, 16'h933C, 16'hCFFF};
    prep();
    for (int i = 0; i < 16; i++) put(i, p[i]);
    go(40);
    exp_wr(0, 16'h2100, 8'h5A, 3'h4);
    exp_wr(1, 16'h2102, 8'h4A, 3'h4);
    exp_wr(2, 16'h2FFF, 8'hFF, 3'h4);
    exp_wr(3, 16'h2100, 8'hFF, 3'h4);
    chk(16'(wa.size()), 16'h0004, "pointer write total");
  endtask

  task automatic t_call_ret();
    prep();
    put(0, 16'hD003);
    put(1, 16'h9300);
    put(2, 16'h2100);
    // Park after the store; a second return would pop an empty stack
    put(3, 16'hCFFF);
    put(4, 16'h9508);
    go(30);
    exp_wr(0, 16'h2FFF, 8'h01, 3'h4);
    exp_wr(1, 16'h2FFE, 8'h00, 3'h4);
    exp_wr(2, 16'h2100, 8'h00, 3'h4);
  endtask

  task automatic t_self_write();
    prep();
    put(0, 16'hE3E4);
    put(1, 16'hE1F2);
    put(2, 16'h95E8);
    put(3, 16'h940E);
    put(4, 16'h8000);
    put(16'h8000, 16'h95E8);
    go(30);
    exp_wr(0, 16'h2FFF, 8'h05, 3'h4);
    chk(16'(spm_n), 16'h0001, "self-write strobes");
    chk(spm_a, 16'h1234, "self-write addr");
    chk(spm_d, 16'h0000, "self-write data");
  endtask

  task automatic t_irq_lock();
    prep();
    irq_vector <= 16'h0100;
    irq_req <= 1'b1;
    put(0, 16'hEF00);
    put(1, 16'hBF0D);
    put(2, 16'h9478);
    put(16'h0100, 16'hCFFF);
    go(40);
    chk(16'(acks), 16'h0001, "ack count");
    chk(16'(ack_idx), 16'h0000, "ack with first push");
    exp_wr(0, 16'h2FF0, 8'h06, 3'h4);
    exp_wr(1, 16'h2FEF, 8'h00, 3'h4);
    chk(16'(wa.size()), 16'h0002, "no flags pushed");
    chk(pm_addr, 16'h0101, "in handler loop");
  endtask

  initial begin
    t_alu_map();
    t_ptr_flags();
    t_call_ret();
    t_self_write();
    t_irq_lock();
    conclude();
  end
endmodule
`default_nettype wire
